//--- verilog/rdh_pkg.sv
// constants, carriers and states for the receive descriptor engine
// assumes a 16-bit shared memory port and an APB register port
package rdh_pkg;

  // apb register offsets (byte addresses)
  localparam logic [11:0] RDH_CTRL_OFF = 12'h000;
  localparam logic [11:0] RDH_BASE_OFF = 12'h004;
  localparam logic [11:0] RDH_STAT_OFF = 12'h008;
  localparam logic [11:0] RDH_FRAMES_OFF = 12'h00C;
  localparam logic [11:0] RDH_DROPS_OFF = 12'h010;

  // control register fields and reset values
  localparam int RDH_CTRL_EN_BIT = 0;
  localparam int RDH_CTRL_JAPAN_BIT = 1;
  localparam int RDH_CTRL_RX_RING_LENGTH_CODE_LSB = 4;
  localparam logic [2:0] RDH_RX_RING_LENGTH_CODE_RST = 3'h0;
  localparam logic [23:0] RDH_BASE_RST = 24'h000000;

  // status register fields
  localparam int RDH_STAT_BUSY_BIT = 8;
  localparam int RDH_STAT_STARVED_BIT = 9;

  // descriptor layout: four 16-bit words, eight bytes
  localparam logic [1:0] RDH_W0 = 2'h0;
  localparam logic [1:0] RDH_W1 = 2'h1;
  localparam logic [1:0] RDH_W2 = 2'h2;
  localparam logic [1:0] RDH_W3 = 2'h3;
  localparam int RDH_OWN_BIT = 15;
  localparam int RDH_SEL_BIT = 14;
  localparam int RDH_START_BIT = 13;
  localparam int RDH_END_BIT = 12;
  localparam int RDH_PRIO_LSB = 10;
  localparam logic [6:0] RDH_IDX_ALL = 7'h7F;
  localparam logic [23:0] RDH_WORD_STEP = 24'h000002;

  // memory request carrier
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } rdh_mem_cmd_s;

  // received byte stream carrier
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic bad;
    logic [1:0] prio;
  } rdh_rx_s;

  typedef enum logic [3:0] {
    S_IDLE, S_RD0, S_RD1, S_RD2, S_FILL, S_WR_BUF, S_WB_RD0, S_WB_WR3, S_WB_WR0, S_DROP
  } rdh_state_e;

endpackage

//--- verilog/rdh_rx_desc.sv
// receive descriptor engine: fills host buffers from a byte stream
// assumes apb master on clk, shared memory answering with mem_ack
//
// Descriptor rules for host and engine
// RULE_01: word0 bit 15 set means the engine owns the descriptor.
// RULE_02: ownership cleared only after filling, and only for a good frame.
// RULE_03: host sets ownership back once it has emptied the buffer.
// RULE_04: after giving a descriptor away, no party touches its words.
// RULE_05: engine ignores word0 bit 14, the host or processor select.
// RULE_06: start flag, bit 13, set in the first buffer of a frame.
// RULE_07: end flag, bit 12, set in the last buffer of a frame.
// RULE_08: one-buffer frame gets both flags and no further chaining.
// RULE_09: in standard mode host writes zeroes into word0 bits 11 to 8.
// RULE_10: in japan mode engine writes priority bits into word0 bits 11:10.
// RULE_11: word0 bits 7:0 are high address bits, never altered by engine.
// RULE_12: word1 holds low address bits, word aligned, never altered.
// RULE_13: word2 holds two's complement buffer length, never altered.
// RULE_14: host programs only even buffer lengths.
// RULE_15: word3 gets two's complement frame length, valid with end flag.
// RULE_16: buffer without end flag has been completely filled.
// RULE_17: each descriptor is four consecutive 16-bit words in the ring.
// RULE_18: ring holds two to the power of the 3-bit length code entries.
// RULE_19: japan mode enable bit selects the priority reporting mode.
// RULE_20: descriptors used in ring order with wrap, only when owned.
`timescale 1ns/1ps
module rdh_rx_desc
  import rdh_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rdh_rx_s rx_in,
  output logic rx_ready,
  output rdh_mem_cmd_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);

  rdh_state_e state_ff, nxt_state;
  logic en_ff, japan_mode_enable_ff;
  logic [2:0] rx_ring_length_code_ff;
  logic [23:0] base_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff, nxt_pslverr;
  logic [6:0] idx_ff, nxt_idx, first_ff, nxt_first, wb_idx_ff, nxt_wb_idx;
  logic [15:0] w0_ff, nxt_w0;
  logic [23:0] buf_ptr_ff, nxt_buf_ptr;
  logic [15:0] len_ff, nxt_len, buf_cnt_ff, nxt_buf_cnt, msg_cnt_ff, nxt_msg_cnt;
  logic [15:0] word_ff, nxt_word;
  logic in_frame_ff, nxt_in_frame, end_ff, nxt_end, starved_ff, nxt_starved;
  logic [1:0] prio_ff, nxt_prio;
  logic rx_ready_ff, nxt_rx_ready;
  rdh_mem_cmd_s mem_ff, nxt_mem;
  logic [15:0] frames_ff, nxt_frames, drops_ff, nxt_drops;

  // apb decode
  wire apb_setup = psel & ~penable & ~pready_ff;
  wire apb_write = psel & penable & pwrite & pready_ff;
  wire hit_ctrl = (paddr == RDH_CTRL_OFF);
  wire hit_base = (paddr == RDH_BASE_OFF);
  wire hit_stat = (paddr == RDH_STAT_OFF);
  wire hit_frames = (paddr == RDH_FRAMES_OFF);
  wire hit_drops = (paddr == RDH_DROPS_OFF);
  wire hit_any = hit_ctrl | hit_base | hit_stat | hit_frames | hit_drops;

  // ring geometry
  // RULE_18 ring size mask
  wire [6:0] ring_mask = RDH_IDX_ALL >> (3'h7 - rx_ring_length_code_ff);
  wire [6:0] idx_next = (idx_ff + 7'h01) & ring_mask;
  wire [6:0] wb_next = (wb_idx_ff + 7'h01) & ring_mask;
  wire [6:0] cur_desc = (state_ff inside {S_WB_RD0, S_WB_WR3, S_WB_WR0}) ? wb_idx_ff : idx_ff;
  // RULE_17 four words per entry
  wire [23:0] desc_base = base_ff + {14'h0000, cur_desc, 3'h0};

  wire take = rx_in.valid & rx_ready_ff;
  wire mem_done = mem_ff.req & mem_ack;
  wire wb_is_last = (wb_idx_ff == idx_ff);
  wire [15:0] neg_msg = 16'h0000 - msg_cnt_ff;

  // RULE_05 select bit passed through untouched
  // RULE_10 priority reported in japan mode
  // RULE_19 mode chosen by enable bit
  wire [1:0] prio_field = japan_mode_enable_ff ? prio_ff : w0_ff[11:10];
  // RULE_02 ownership returned
  // RULE_06 start flag on first buffer
  // RULE_07 end flag on last buffer
  // RULE_08 single buffer gets both
  // RULE_11 high address bits kept
  wire [15:0] w0_new = {1'b0, w0_ff[RDH_SEL_BIT], wb_idx_ff == first_ff, wb_is_last, prio_field, w0_ff[9:0]};

  wire [31:0] stat_word = {22'h000000, starved_ff, state_ff != S_IDLE, 1'b0, idx_ff};
  wire [31:0] ctrl_word = {25'h0000000, rx_ring_length_code_ff, 2'h0, japan_mode_enable_ff, en_ff};

  always_comb begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (apb_setup) begin
      nxt_pslverr = ~hit_any;
      if (!pwrite) begin
        nxt_prdata = hit_ctrl ? ctrl_word :
                     hit_base ? {8'h00, base_ff} :
                     hit_stat ? stat_word :
                     hit_frames ? {16'h0000, frames_ff} :
                     hit_drops ? {16'h0000, drops_ff} : 32'h00000000;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_first = first_ff;
    nxt_wb_idx = wb_idx_ff;
    nxt_w0 = w0_ff;
    nxt_buf_ptr = buf_ptr_ff;
    nxt_len = len_ff;
    nxt_buf_cnt = buf_cnt_ff;
    nxt_msg_cnt = msg_cnt_ff;
    nxt_word = word_ff;
    nxt_in_frame = in_frame_ff;
    nxt_end = end_ff;
    nxt_starved = starved_ff;
    nxt_prio = prio_ff;
    nxt_mem = mem_ff;
    nxt_frames = frames_ff;
    nxt_drops = drops_ff;
    case (state_ff)
      S_IDLE: begin
        if (en_ff) begin
          nxt_state = S_RD0;
        end
      end
      S_RD0: begin
        if (!mem_ff.req) begin
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: desc_base, wdata: 16'h0000};
        end else if (mem_ack) begin
          nxt_mem.req = 1'b0;
          // RULE_01 owner check
          // RULE_20 never use a foreign entry
          if (mem_rdata[RDH_OWN_BIT]) begin
            nxt_starved = 1'b0;
            nxt_buf_ptr[23:16] = mem_rdata[7:0];
            nxt_state = S_RD1;
          end else begin
            nxt_starved = 1'b1;
            if (in_frame_ff) begin
              nxt_idx = first_ff;
              nxt_in_frame = 1'b0;
              nxt_drops = drops_ff + 16'h0001;
              nxt_state = S_DROP;
            end else begin
              nxt_state = S_IDLE;
            end
          end
        end
      end
      S_RD1: begin
        if (!mem_ff.req) begin
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: desc_base + RDH_WORD_STEP, wdata: 16'h0000};
        end else if (mem_ack) begin
          nxt_mem.req = 1'b0;
          // RULE_12 word aligned buffer
          nxt_buf_ptr[15:0] = {mem_rdata[15:1], 1'b0};
          nxt_state = S_RD2;
        end
      end
      S_RD2: begin
        if (!mem_ff.req) begin
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: desc_base + {RDH_WORD_STEP[22:0], 1'b0}, wdata: 16'h0000};
        end else if (mem_ack) begin
          nxt_mem.req = 1'b0;
          // RULE_13 length read, never written
          nxt_len = 16'h0000 - mem_rdata;
          nxt_buf_cnt = 16'h0000;
          nxt_state = S_FILL;
        end
      end
      S_FILL: begin
        if (take) begin
          nxt_prio = rx_in.prio;
          nxt_buf_cnt = buf_cnt_ff + 16'h0001;
          nxt_msg_cnt = msg_cnt_ff + 16'h0001;
          if (rx_in.last && rx_in.bad) begin
            // RULE_02 bad frame keeps ownership
            nxt_idx = first_ff;
            nxt_in_frame = 1'b0;
            nxt_msg_cnt = 16'h0000;
            nxt_drops = drops_ff + 16'h0001;
            nxt_state = S_IDLE;
          end else if (!buf_cnt_ff[0]) begin
            nxt_word = {rx_in.data, 8'h00};
            nxt_end = rx_in.last;
            nxt_state = rx_in.last ? S_WR_BUF : S_FILL;
          end else begin
            nxt_word = {word_ff[15:8], rx_in.data};
            nxt_end = rx_in.last;
            nxt_state = S_WR_BUF;
          end
        end
      end
      S_WR_BUF: begin
        if (!mem_ff.req) begin
          nxt_mem = '{req: 1'b1, we: 1'b1, addr: buf_ptr_ff, wdata: word_ff};
        end else if (mem_ack) begin
          nxt_mem.req = 1'b0;
          nxt_buf_ptr = buf_ptr_ff + RDH_WORD_STEP;
          if (end_ff) begin
            nxt_wb_idx = first_ff;
            nxt_state = S_WB_RD0;
          end else if (buf_cnt_ff == len_ff) begin
            // RULE_16 chain only from a full buffer
            // RULE_14 even lengths keep words whole
            nxt_idx = idx_next;
            nxt_in_frame = 1'b1;
            nxt_state = S_RD0;
          end else begin
            nxt_state = S_FILL;
          end
        end
      end
      S_WB_RD0: begin
        if (!mem_ff.req) begin
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: desc_base, wdata: 16'h0000};
        end else if (mem_ack) begin
          nxt_mem.req = 1'b0;
          nxt_w0 = mem_rdata;
          // RULE_04 length word before ownership word
          nxt_state = wb_is_last ? S_WB_WR3 : S_WB_WR0;
        end
      end
      S_WB_WR3: begin
        if (!mem_ff.req) begin
          // RULE_15 negated frame length
          nxt_mem = '{req: 1'b1, we: 1'b1, addr: desc_base + {21'h000000, RDH_W3, 1'b0}, wdata: neg_msg};
        end else if (mem_ack) begin
          nxt_mem.req = 1'b0;
          nxt_state = S_WB_WR0;
        end
      end
      S_WB_WR0: begin
        if (!mem_ff.req) begin
          nxt_mem = '{req: 1'b1, we: 1'b1, addr: desc_base, wdata: w0_new};
        end else if (mem_ack) begin
          nxt_mem.req = 1'b0;
          if (wb_is_last) begin
            // RULE_20 ring order with wrap
            nxt_idx = idx_next;
            nxt_first = idx_next;
            nxt_in_frame = 1'b0;
            nxt_end = 1'b0;
            nxt_msg_cnt = 16'h0000;
            nxt_frames = frames_ff + 16'h0001;
            nxt_state = S_IDLE;
          end else begin
            nxt_wb_idx = wb_next;
            nxt_state = S_WB_RD0;
          end
        end
      end
      S_DROP: begin
        if (take && rx_in.last) begin
          nxt_msg_cnt = 16'h0000;
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    nxt_rx_ready = (nxt_state == S_FILL || nxt_state == S_DROP) && !take;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_ff <= 1'b0;
      japan_mode_enable_ff <= 1'b0;
      rx_ring_length_code_ff <= RDH_RX_RING_LENGTH_CODE_RST;
      base_ff <= RDH_BASE_RST;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= apb_setup;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      if (apb_write && hit_ctrl) begin
        en_ff <= pwdata[RDH_CTRL_EN_BIT];
        japan_mode_enable_ff <= pwdata[RDH_CTRL_JAPAN_BIT];
        rx_ring_length_code_ff <= pwdata[RDH_CTRL_RX_RING_LENGTH_CODE_LSB +: 3];
      end
      if (apb_write && hit_base) begin
        base_ff <= {pwdata[23:1], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= S_IDLE;
      idx_ff <= 7'h00;
      first_ff <= 7'h00;
      wb_idx_ff <= 7'h00;
      w0_ff <= 16'h0000;
      buf_ptr_ff <= 24'h000000;
      len_ff <= 16'h0000;
      buf_cnt_ff <= 16'h0000;
      msg_cnt_ff <= 16'h0000;
      word_ff <= 16'h0000;
      in_frame_ff <= 1'b0;
      end_ff <= 1'b0;
      starved_ff <= 1'b0;
      prio_ff <= 2'h0;
      rx_ready_ff <= 1'b0;
      mem_ff <= '0;
      frames_ff <= 16'h0000;
      drops_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      first_ff <= nxt_first;
      wb_idx_ff <= nxt_wb_idx;
      w0_ff <= nxt_w0;
      buf_ptr_ff <= nxt_buf_ptr;
      len_ff <= nxt_len;
      buf_cnt_ff <= nxt_buf_cnt;
      msg_cnt_ff <= nxt_msg_cnt;
      word_ff <= nxt_word;
      in_frame_ff <= nxt_in_frame;
      end_ff <= nxt_end;
      starved_ff <= nxt_starved;
      prio_ff <= nxt_prio;
      rx_ready_ff <= nxt_rx_ready;
      mem_ff <= nxt_mem;
      frames_ff <= nxt_frames;
      drops_ff <= nxt_drops;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign rx_ready = rx_ready_ff;
  assign mem_cmd = mem_ff;

  // checks
  wire wr0_out = mem_ff.req && state_ff == S_WB_WR0;

  a_own_bit_clear: assert property (@(posedge clk) disable iff (reset) // RULE_02
    wr0_out |-> !mem_ff.wdata[RDH_OWN_BIT] && mem_ff.we)
    else $error("ownership write does not clear the owner bit");

  a_unowned_skip: assert property (@(posedge clk) disable iff (reset) // RULE_20
    (state_ff == S_RD0 && mem_done && !mem_rdata[RDH_OWN_BIT]) |=> state_ff != S_RD1)
    else $error("unowned descriptor was used");

  a_start_flag_set: assert property (@(posedge clk) disable iff (reset) // RULE_06
    wr0_out |-> mem_ff.wdata[RDH_START_BIT] == (wb_idx_ff == first_ff))
    else $error("start flag wrong");

  a_end_flag_set: assert property (@(posedge clk) disable iff (reset) // RULE_07
    wr0_out |-> mem_ff.wdata[RDH_END_BIT] == (wb_idx_ff == idx_ff))
    else $error("end flag wrong");

  a_high_addr_kept: assert property (@(posedge clk) disable iff (reset) // RULE_11
    wr0_out |-> mem_ff.wdata[7:0] == w0_ff[7:0] && mem_ff.wdata[9:8] == w0_ff[9:8])
    else $error("high address bits altered");

  a_select_kept: assert property (@(posedge clk) disable iff (reset) // RULE_05
    wr0_out |-> mem_ff.wdata[RDH_SEL_BIT] == w0_ff[RDH_SEL_BIT])
    else $error("select bit altered");

  a_prio_report: assert property (@(posedge clk) disable iff (reset) // RULE_10
    (wr0_out && japan_mode_enable_ff) |-> mem_ff.wdata[11:10] == prio_ff)
    else $error("priority bits not reported");

  a_msg_len_word: assert property (@(posedge clk) disable iff (reset) // RULE_15
    (mem_ff.req && state_ff == S_WB_WR3) |->
      mem_ff.wdata == neg_msg && mem_ff.addr == desc_base + {21'h000000, RDH_W3, 1'b0})
    else $error("message length word wrong");

  a_no_addr_write: assert property (@(posedge clk) disable iff (reset) // RULE_13
    (mem_ff.req && mem_ff.we && state_ff != S_WR_BUF) |->
      mem_ff.addr == desc_base || mem_ff.addr == desc_base + {21'h000000, RDH_W3, 1'b0})
    else $error("engine wrote an address or length word");

  a_len_before_own: assert property (@(posedge clk) disable iff (reset) // RULE_04
    (state_ff == S_WB_WR3 && mem_done) |=> state_ff == S_WB_WR0)
    else $error("length written after ownership release");

  a_ring_wrap: assert property (@(posedge clk) disable iff (reset) // RULE_18
    (idx_ff & ~ring_mask) == 7'h00 || $changed(rx_ring_length_code_ff))
    else $error("ring index beyond ring length");

  a_apb_answer: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer timing");

endmodule

//--- testbench/rdh_mem_model.sv
// shared host memory model: 256 words of 16 bits, answers mem_cmd
// assumes the testbench sets lat (extra wait cycles) and writes words directly
`timescale 1ns/1ps
module rdh_mem_model
  import rdh_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire rdh_mem_cmd_s mem_cmd,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] words [0:255];
  logic [3:0] wait_ff;

  // memory changes only on a requested write
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_ack <= 1'b0;
      wait_ff <= 4'h0;
      mem_rdata <= 16'hA5A5;
    end else if (mem_ack || !mem_cmd.req) begin
      mem_ack <= 1'b0;
      wait_ff <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_ff >= lat) begin
      mem_ack <= 1'b1;
      if (mem_cmd.we) begin
        words[mem_cmd.addr[8:1]] <= mem_cmd.wdata;
      end else begin
        mem_rdata <= words[mem_cmd.addr[8:1]];
      end
    end else begin
      wait_ff <= wait_ff + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

//--- testbench/receive_descriptor_handling_test.sv
// testbench: apb register access, byte stream frames, host memory checks
// assumes rdh_rx_desc and rdh_mem_model, one 50 MHz clock
`timescale 1ns/1ps
module receive_descriptor_handling_test
  import rdh_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rdh_rx_s rx_in = '0;
  logic rx_ready;
  rdh_mem_cmd_s mem_cmd;
  logic mem_ack;
  logic [15:0] mem_rdata;
  logic [3:0] lat = 4'h3;
  logic [31:0] q_seen;
  logic e_seen;
  int miscompares = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  rdh_rx_desc dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in(rx_in), .rx_ready(rx_ready), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  rdh_mem_model mem (.clk(clk), .reset(reset), .mem_cmd(mem_cmd), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  task automatic finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic timed_out;
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    finish_test();
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) timed_out();
    q_seen = prdata;
    e_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    check(q_seen, exp);
    check({31'h0, e_seen}, {31'h0, err});
  endtask

  // repeat a read until the counter shows the expected value
  task automatic poll(input logic [11:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (q_seen !== exp && n < 100);
    check(q_seen, exp);
    if (q_seen !== exp) finish_test();
  endtask

  // offer one byte and hold it until taken
  task automatic send(input logic [7:0] b, input logic lst, input logic bd, input logic [1:0] pr);
    int n;
    @(posedge clk);
    rx_in <= '{valid: 1'b1, data: b, last: lst, bad: bd, prio: pr};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rx_ready !== 1'b1 && n < 500);
    if (rx_ready !== 1'b1) timed_out();
    rx_in.valid <= 1'b0;
  endtask

  task automatic put(input logic [8:0] a, input logic [15:0] d);
    mem.words[a[8:1]] = d;
  endtask

  task automatic cmp(input logic [8:0] a, input logic [15:0] exp);
    check({16'h0, mem.words[a[8:1]]}, {16'h0, exp});
  endtask

  initial begin
    // host builds a two-entry ring at 0x40, select bit set in entry 0 word0 only
    put(9'h040, 16'hC000);
    put(9'h042, 16'h0080);
    put(9'h044, 16'hFFFC);
    put(9'h048, 16'h8000);
    put(9'h04A, 16'h0090);
    put(9'h04C, 16'hFFFC);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(RDH_CTRL_OFF, 32'h0, 1'b0);
    rd(RDH_BASE_OFF, 32'h0, 1'b0);
    rd(12'h014, 32'h0, 1'b1);
    apb(1'b1, RDH_BASE_OFF, 32'h40);
    apb(1'b1, RDH_CTRL_OFF, 32'h11);
    rd(RDH_CTRL_OFF, 32'h11, 1'b0);
    // six bytes chain over two four-byte buffers, slow memory
    for (int i = 0; i < 6; i++) begin
      send(8'hA1 + 8'(i * 17), i == 5, 1'b0, 2'b00);
    end
    poll(RDH_FRAMES_OFF, 32'h1);
    cmp(9'h080, 16'hA1B2);
    cmp(9'h082, 16'hC3D4);
    cmp(9'h090, 16'hE5F6);
    cmp(9'h040, 16'h6000);
    cmp(9'h042, 16'h0080);
    cmp(9'h044, 16'hFFFC);
    cmp(9'h048, 16'h1000);
    cmp(9'h04E, 16'hFFFA);
    // host returns entry 0, japan mode, prompt memory, one byte
    @(posedge clk);
    lat <= 4'h0;
    put(9'h040, 16'h805A);
    apb(1'b1, RDH_CTRL_OFF, 32'h13);
    send(8'h77, 1'b1, 1'b0, 2'b10);
    poll(RDH_FRAMES_OFF, 32'h2);
    cmp(9'h040, 16'h385A);
    cmp(9'h046, 16'hFFFF);
    cmp(9'h080, 16'h7700);
    // bad frame into entry 1 keeps ownership with the engine
    put(9'h048, 16'h8000);
    send(8'h01, 1'b0, 1'b0, 2'b00);
    send(8'h02, 1'b1, 1'b1, 2'b00);
    poll(RDH_DROPS_OFF, 32'h1);
    cmp(9'h048, 16'h8000);
    // next good frame reuses entry 1, odd length
    send(8'h11, 1'b0, 1'b0, 2'b00);
    send(8'h22, 1'b0, 1'b0, 2'b00);
    send(8'h33, 1'b1, 1'b0, 2'b01);
    poll(RDH_FRAMES_OFF, 32'h3);
    cmp(9'h090, 16'h1122);
    cmp(9'h092, 16'h3300);
    cmp(9'h048, 16'h3400);
    cmp(9'h04E, 16'hFFFD);
    cmp(9'h04A, 16'h0090);
    cmp(9'h040, 16'h385A);
    // entry 0 returned alone: frame outgrows it, entry 1 not owned, frame dropped
    put(9'h040, 16'h8000);
    for (int i = 0; i < 5; i++) begin
      send(8'h50 + 8'(i), i == 4, 1'b0, 2'b00);
    end
    poll(RDH_DROPS_OFF, 32'h2);
    cmp(9'h040, 16'h8000);
    cmp(9'h048, 16'h3400);
    apb(1'b0, RDH_STAT_OFF, 32'h0);
    check({25'h0, q_seen[6:0]}, 32'h0);
    finish_test();
  end
endmodule
